// File: ecrb_map.vh
// register map, field positions, reset values and key codes of the
// configuration portal and channel capability registers
// assumes inclusion by ecrb_top.v only
`ifndef ECRB_MAP_VH
`define ECRB_MAP_VH

`define ECRB_BASE_RESET 16'h008C
`define ECRB_KEY_ENABLE 8'h55
`define ECRB_KEY_DISABLE 8'hAA
`define ECRB_IDX_BANK_SEL 8'h07
`define ECRB_IDX_BASE_LO 8'h36
`define ECRB_IDX_BASE_HI 8'h37
`define ECRB_GLOBAL_LAST 8'h2F
`define ECRB_BANK_FIRST 8'h30
`define ECRB_BANK_HOST 8'h00
`define ECRB_BANK_LPC 8'h01
`define ECRB_BANK_RESET 8'h00
`define ECRB_READ_RESERVED 8'h00
`define ECRB_READ_LOCKED 8'hFF

`define ECRB_LOC_PERIPH 8'h10
`define ECRB_LOC_WIRE 8'h20

`define ECRB_PC_RDREQ_HI 14
`define ECRB_PC_RDREQ_LO 12
`define ECRB_PC_PAYSEL_HI 10
`define ECRB_PC_PAYSEL_LO 8
`define ECRB_PC_PAYSUP_HI 6
`define ECRB_PC_PAYSUP_LO 4
`define ECRB_PC_BME 2
`define ECRB_CH_READY 1
`define ECRB_CH_ENABLE 0
`define ECRB_PC_FIELD_RESET 3'h1
`define ECRB_PC_PAYSUP 3'h1
`define ECRB_PC_BME_RESET 1'h0
`define ECRB_PC_EN_RESET 1'h1

`define ECRB_VW_OPCNT_HI 21
`define ECRB_VW_OPCNT_LO 16
`define ECRB_VW_SUPCNT_HI 13
`define ECRB_VW_SUPCNT_LO 8
`define ECRB_VW_SUPCNT 6'h3F
`define ECRB_VW_OPCNT_RESET 6'h00
`define ECRB_VW_EN_RESET 1'h0

`endif

// File: ecrb_top.v
// configuration portal, bank select and ecspi channel capability registers
// assumes a link decoder that presents one host i/o cycle or one
// configuration command per strobe, synchronous to I_CLOCK
//
// What this block does
// [R1] portal decodes at 008Ch select and 008Dh value after reset
// [R2] portal base movable to any even address, value byte at odd
// [R3] all other host i/o and memory cycles pass to lpc at once
// [R4] select byte picks register; value byte reads and writes it
// [R5] register numbers 00h to 2Fh are global and never banked
// [R6] writing register 07h chooses the bank seen at 30h to FFh
// [R7] bank 00h is host interface, bank 01h is lpc side
// [R8] reserved writes change nothing; reserved reads give 00h
// [R9] portal starts locked; 55h to select byte unlocks it
// [R10] every reset, platform reset too, relocks the portal
// [R11] AAh to select byte locks until 55h is written again
// [R12] portal bytes stay claimed while locked, never passed to lpc
// [R13] link reset also asserts the platform reset domain
// [R14] power-on reset resets all but the banked storage, and both other domains
// [R15] peripheral 10h: read request and payload select, default 001b
// [R16] peripheral supported payload bits 6:4 read 001b fixed
// [R17] ready mirrors enable; peripheral defaults 1, wire defaults 0
// [R18] wire 20h operating count bits 21:16, default 0, link reset
// [R19] wire supported count 3Fh; reserved channel bits read zero
// [R20] channel registers reached only by link configuration commands
// [R21] locked portal: value writes ignored, value reads return FFh
`timescale 1ns/1ps
`include "ecrb_map.vh"

module ecrb_top #(
   parameter BANK_REG_COUNT = 208
) (
   input wire I_CLOCK, // 40 MHz clock
   input wire I_RST_N, // platform reset, unused name kept for style
   input wire I_POWER_ON_RESET_IN_N, // power-on reset, active low
   input wire I_LINK_RESET_N, // link reset, active low
   input wire I_PLATFORM_RESET_N, // platform reset, active low
   input wire I_IO_STB, // one-cycle host i/o cycle strobe
   input wire I_IO_WR, // 1 write, 0 read
   input wire I_IO_MEM, // 1 memory cycle, 0 i/o cycle
   input wire [15:0] I_IO_ADDR, // host address (low 16 bits)
   input wire [7:0] I_IO_WDATA, // host write byte
   input wire I_CFG_STB, // one-cycle link configuration command
   input wire I_CFG_WR, // 1 set, 0 get
   input wire [7:0] I_CFG_LOC, // configuration location
   input wire [31:0] I_CFG_WDATA, // set data
   output reg O_IO_DONE, // portal cycle claimed and done
   output reg [7:0] O_IO_RDATA, // portal read byte
   output reg O_IO_FWD, // cycle forwarded to lpc side
   output reg O_CFG_DONE, // configuration command done
   output reg [31:0] O_CFG_RDATA, // get data
   output reg O_PORTAL_OPEN, // portal unlocked
   output reg [7:0] O_BANK_SEL, // selected bank
   output reg [15:0] O_PORTAL_BASE, // current portal base
   output reg O_PLATFORM_RESET_N, // platform reset domain out
   output reg O_LINK_RESET_N // link reset domain out
);

   reg [7:0] index;
   reg [15:0] base;
   reg open;
   reg [7:0] bank_select;
   reg [7:0] bank_mem [0:2*BANK_REG_COUNT-1];
   reg [2:0] pc_rdreq;
   reg [2:0] pc_paysel;
   reg pc_bme;
   reg pc_en;
   reg [5:0] vw_opcnt;
   reg vw_en;
   reg [7:0] rd_byte;
   reg [31:0] cfg_rd;
   wire por = ~I_POWER_ON_RESET_IN_N;
   wire link_rst = por | ~I_LINK_RESET_N; // see [R14]
   wire plt_rst = link_rst | ~I_PLATFORM_RESET_N; // see [R13]
   wire hit_idx = !I_IO_MEM && I_IO_ADDR == base; // see [R1]
   wire hit_dat = !I_IO_MEM && I_IO_ADDR == {base[15:1], 1'b1};
   wire is_global = index <= `ECRB_GLOBAL_LAST; // see [R5]
   wire banked_ok = !is_global &&
      (bank_select == `ECRB_BANK_HOST || bank_select == `ECRB_BANK_LPC);
   // bank 01h is stacked right above bank 00h so the array has no holes
   wire [31:0] bank_addr = (bank_select[0] ? BANK_REG_COUNT : 0) +
      {24'h000000, index} - {24'h000000, `ECRB_BANK_FIRST}; // see [R7]
   wire [31:0] pc_word = {17'h00000, pc_rdreq, 1'b0, pc_paysel, 1'b0,
      `ECRB_PC_PAYSUP, 1'b0, pc_bme, pc_en, pc_en}; // see [R16] [R17]
   wire [31:0] vw_word = {10'h000, vw_opcnt, 2'b00, `ECRB_VW_SUPCNT,
      6'h00, vw_en, vw_en}; // see [R19] [R17]

   // portal read mux; locked reads give a constant
   always @* begin
      rd_byte = `ECRB_READ_RESERVED; // see [R8]
      if (!open)
         rd_byte = `ECRB_READ_LOCKED; // see [R21]
      else if (index == `ECRB_IDX_BANK_SEL)
         rd_byte = bank_select;
      else if (index == `ECRB_IDX_BASE_LO)
         rd_byte = base[7:0];
      else if (index == `ECRB_IDX_BASE_HI)
         rd_byte = base[15:8];
      else if (banked_ok)
         rd_byte = bank_mem[bank_addr]; // see [R4]
   end

   always @* begin
      cfg_rd = 32'h00000000;
      if (I_CFG_LOC == `ECRB_LOC_PERIPH)
         cfg_rd = pc_word;
      else if (I_CFG_LOC == `ECRB_LOC_WIRE)
         cfg_rd = vw_word;
   end

   // portal state: every reset domain relocks it
   always @(posedge I_CLOCK) begin
      if (plt_rst) begin
         open <= 1'b0; // see [R10]
         index <= 8'h00;
         bank_select <= `ECRB_BANK_RESET;
         base <= `ECRB_BASE_RESET; // see [R1]
      end else if (I_IO_STB && I_IO_WR) begin
         if (hit_idx) begin
            index <= I_IO_WDATA;
            if (I_IO_WDATA == `ECRB_KEY_ENABLE)
               open <= 1'b1; // see [R9]
            else if (I_IO_WDATA == `ECRB_KEY_DISABLE)
               open <= 1'b0; // see [R11]
         end else if (hit_dat && open) begin
            if (index == `ECRB_IDX_BANK_SEL)
               bank_select <= I_IO_WDATA; // see [R6]
            else if (index == `ECRB_IDX_BASE_LO)
               base <= {base[15:8], I_IO_WDATA[7:1], 1'b0}; // see [R2]
            else if (index == `ECRB_IDX_BASE_HI)
               base <= {I_IO_WDATA, base[7:0]};
         end
      end
   end

   // banked storage is not reset; a real logical device would hold
   // defined fields here, this array only gives them read-back
   always @(posedge I_CLOCK) begin
      if (!plt_rst && I_IO_STB && I_IO_WR && hit_dat && open && banked_ok)
         bank_mem[bank_addr] <= I_IO_WDATA; // see [R8] [R21]
   end

   // peripheral channel fields, platform reset domain
   always @(posedge I_CLOCK) begin
      if (plt_rst) begin
         pc_rdreq <= `ECRB_PC_FIELD_RESET; // see [R15]
         pc_paysel <= `ECRB_PC_FIELD_RESET;
         pc_bme <= `ECRB_PC_BME_RESET;
         pc_en <= `ECRB_PC_EN_RESET; // see [R17]
      end else if (I_CFG_STB && I_CFG_WR &&
            I_CFG_LOC == `ECRB_LOC_PERIPH) begin // see [R20]
         pc_rdreq <= I_CFG_WDATA[`ECRB_PC_RDREQ_HI:`ECRB_PC_RDREQ_LO];
         pc_paysel <= I_CFG_WDATA[`ECRB_PC_PAYSEL_HI:`ECRB_PC_PAYSEL_LO];
         pc_bme <= I_CFG_WDATA[`ECRB_PC_BME];
         pc_en <= I_CFG_WDATA[`ECRB_CH_ENABLE];
      end
   end

   // wire channel fields, link reset domain
   always @(posedge I_CLOCK) begin
      if (link_rst) begin
         vw_opcnt <= `ECRB_VW_OPCNT_RESET; // see [R18]
         vw_en <= `ECRB_VW_EN_RESET;
      end else if (I_CFG_STB && I_CFG_WR && I_CFG_LOC == `ECRB_LOC_WIRE) begin
         vw_opcnt <= I_CFG_WDATA[`ECRB_VW_OPCNT_HI:`ECRB_VW_OPCNT_LO];
         vw_en <= I_CFG_WDATA[`ECRB_CH_ENABLE];
      end
   end

   // answers: portal cycles are claimed even while locked
   always @(posedge I_CLOCK) begin
      if (plt_rst) begin
         O_IO_DONE <= 1'b0;
         O_IO_RDATA <= 8'h00;
         O_IO_FWD <= 1'b0;
         O_CFG_DONE <= 1'b0;
         O_CFG_RDATA <= 32'h00000000;
      end else begin
         O_IO_DONE <= I_IO_STB && (hit_idx || hit_dat); // see [R12]
         O_IO_FWD <= I_IO_STB && !hit_idx && !hit_dat; // see [R3]
         O_IO_RDATA <= (I_IO_STB && !I_IO_WR && hit_dat) ? rd_byte : 8'h00;
         O_CFG_DONE <= I_CFG_STB;
         O_CFG_RDATA <= (I_CFG_STB && !I_CFG_WR) ? cfg_rd : 32'h00000000;
      end
   end

   always @(posedge I_CLOCK) begin
      O_PLATFORM_RESET_N <= ~plt_rst; // see [R13]
      O_LINK_RESET_N <= ~link_rst; // see [R14]
      O_PORTAL_OPEN <= open & ~plt_rst;
      O_BANK_SEL <= plt_rst ? `ECRB_BANK_RESET : bank_select;
      O_PORTAL_BASE <= plt_rst ? `ECRB_BASE_RESET : base;
   end

endmodule // ecrb_top

// File: ecrb_monitor.sv
// assertions on the portal, the reset domains and the channel registers
// bound into ecrb_top; sees its ports only
`timescale 1ns/1ps
module ecrb_monitor (
   input wire I_CLOCK, I_IO_STB, I_IO_WR, I_IO_MEM, I_CFG_STB, // strobes
   input wire I_POWER_ON_RESET_IN_N, I_LINK_RESET_N, // resets
   input wire [15:0] I_IO_ADDR, O_PORTAL_BASE, // address, base
   input wire [7:0] I_IO_WDATA, O_IO_RDATA, I_CFG_LOC, // bytes
   input wire I_CFG_WR, O_IO_DONE, O_IO_FWD, O_PORTAL_OPEN, // flags
   input wire [31:0] O_CFG_RDATA, // get data
   input wire I_PLATFORM_RESET_N, O_PLATFORM_RESET_N, O_LINK_RESET_N // resets
);
   wire rst_n = I_POWER_ON_RESET_IN_N & I_LINK_RESET_N & I_PLATFORM_RESET_N;
   wire hit = I_IO_STB & ~I_IO_MEM &
      (I_IO_ADDR[15:1] == O_PORTAL_BASE[15:1]);
   wire key = hit & I_IO_WR & ~I_IO_ADDR[0];
   wire rd10 = I_CFG_STB & ~I_CFG_WR & (I_CFG_LOC == 8'h10);
   wire rd20 = I_CFG_STB & ~I_CFG_WR & (I_CFG_LOC == 8'h20);
   reg [1:0] quiet; // the open flag lags a key write, so wait that out
   always @(posedge I_CLOCK)
      quiet <= (I_IO_STB | ~rst_n) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!rst_n);
   claim_a: assert property (hit |=> O_IO_DONE && !O_IO_FWD)
      else $error("portal cycle not claimed");
   pass_a: assert property (I_IO_STB && !hit |=> O_IO_FWD)
      else $error("cycle not forwarded");
   unlock_key_a: assert property (key && I_IO_WDATA == 8'h55
      |-> ##[1:2] O_PORTAL_OPEN) else $error("key did not unlock");
   lock_key_a: assert property (key && I_IO_WDATA == 8'hAA
      |-> ##[1:2] !O_PORTAL_OPEN) else $error("key did not lock");
   locked_read_a: assert property (hit && !I_IO_WR && I_IO_ADDR[0]
      && !O_PORTAL_OPEN && quiet == 2'h3 |=> O_IO_RDATA == 8'hFF)
      else $error("locked read gave data");
   periph_fixed_a: assert property (rd10 |=> O_CFG_RDATA[6:4] == 3'h1
      && O_CFG_RDATA[1] == O_CFG_RDATA[0]) else $error("peripheral get");
   wire_fixed_a: assert property (rd20 |=> O_CFG_RDATA[13:8] == 6'h3F
      && O_CFG_RDATA[31:22] == 10'h0) else $error("wire get");
   link_plat_a: assert property (disable iff (!I_POWER_ON_RESET_IN_N)
      !I_LINK_RESET_N |=> !O_PLATFORM_RESET_N) else $error("link reset");
   por_all_a: assert property (disable iff (1'b0)
      !I_POWER_ON_RESET_IN_N |=> !O_LINK_RESET_N && !O_PLATFORM_RESET_N)
      else $error("power-on reset");
   relock_a: assert property (disable iff (1'b0)
      !I_PLATFORM_RESET_N |=> !O_PORTAL_OPEN) else $error("no relock");
   cover property (key && I_IO_WDATA == 8'h55);
   cover property (hit && I_IO_ADDR[0] && O_PORTAL_OPEN);
   cover property (I_CFG_STB && I_CFG_WR);
endmodule // ecrb_monitor
bind ecrb_top ecrb_monitor mon (.*);

// File: ecrb_host.sv
// host model: one host i/o cycle or one configuration command per call
// assumes the block answers at the taking edge, by the next falling edge
`timescale 1ns/1ps
module ecrb_host (
   input wire i_clock, // clock
   input wire i_ans, // any answer
   output reg o_stb, o_wr, o_mem, o_cstb, o_cwr, o_late, // controls
   output reg [15:0] o_addr, // address
   output reg [7:0] o_wd, o_loc, // byte, location
   output reg [31:0] o_cwd // set data
);
   initial {o_stb, o_wr, o_mem, o_cstb, o_cwr, o_late} = 6'h0;
   initial {o_addr, o_wd, o_loc, o_cwd} = 64'h0;
   task fin;
      begin
         @(negedge i_clock);
         {o_stb, o_cstb} = 2'h0;
         // address, write byte and set data flip so no stale value passes for a hold
         {o_addr, o_wd, o_cwd} = ~{o_addr, o_wd, o_cwd};
         if (i_ans !== 1'b1) o_late = 1'b1;
      end
   endtask
   task io(input w, input m, input [15:0] a, input [7:0] d);
      begin
         @(negedge i_clock);
         {o_stb, o_wr, o_mem, o_addr, o_wd} = {1'b1, w, m, a, d};
         fin;
      end
   endtask
   task cfg(input w, input [7:0] l, input [31:0] d);
      begin
         @(negedge i_clock);
         {o_cstb, o_cwr, o_loc, o_cwd} = {1'b1, w, l, d};
         fin;
      end
   endtask
endmodule // ecrb_host

// File: ecrb_top_tb.sv
// bench of the portal and channel registers
// drives the block through the host model at falling clock edges
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
   n_mismatch = n_mismatch + 1; \
   $display("CHECK FAILED at %0t: %h vs %h", $time, g, e); end end
module ecrb_top_tb;
   reg I_CLOCK = 1'b0;
   reg I_POWER_ON_RESET_IN_N = 1'b0, I_LINK_RESET_N = 1'b0;
   reg I_PLATFORM_RESET_N = 1'b0;
   wire I_RST_N = 1'b1;
   wire I_IO_STB, I_IO_WR, I_IO_MEM, I_CFG_STB, I_CFG_WR, late;
   wire [15:0] I_IO_ADDR, O_PORTAL_BASE;
   wire [7:0] I_IO_WDATA, I_CFG_LOC, O_IO_RDATA, O_BANK_SEL;
   wire [31:0] I_CFG_WDATA, O_CFG_RDATA;
   wire O_IO_DONE, O_IO_FWD, O_CFG_DONE, O_PORTAL_OPEN;
   wire O_PLATFORM_RESET_N, O_LINK_RESET_N;
   reg [15:0] pb = 16'h008C;
   integer n_mismatch = 0, compares = 0, i;
   always #12.5 I_CLOCK = ~I_CLOCK;
   ecrb_host host (.i_clock(I_CLOCK),
      .i_ans(O_IO_DONE | O_IO_FWD | O_CFG_DONE), .o_stb(I_IO_STB),
      .o_wr(I_IO_WR), .o_mem(I_IO_MEM), .o_addr(I_IO_ADDR),
      .o_wd(I_IO_WDATA), .o_cstb(I_CFG_STB), .o_cwr(I_CFG_WR),
      .o_loc(I_CFG_LOC), .o_cwd(I_CFG_WDATA), .o_late(late));
   ecrb_top dut (.*);
   task end_of_test;
      begin
         $display("mismatches %0d compares %0d", n_mismatch, compares);
         if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   always @(posedge late) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
   task rst(input [2:0] m); // power-on, link, platform; 0 asserts
      begin
         @(negedge I_CLOCK);
         {I_POWER_ON_RESET_IN_N, I_LINK_RESET_N, I_PLATFORM_RESET_N} = m;
         repeat (2) @(negedge I_CLOCK);
         `CHK(O_PLATFORM_RESET_N, 1'b0)
         `CHK(O_LINK_RESET_N, m[2] & m[1])
         {I_POWER_ON_RESET_IN_N, I_LINK_RESET_N, I_PLATFORM_RESET_N} = 3'h7;
      end
   endtask
   task wr_reg(input [7:0] idx, input [7:0] v);
      begin
         host.io(1'b1, 1'b0, pb, idx);
         host.io(1'b1, 1'b0, pb + 16'h1, v);
      end
   endtask
   task rd_reg(input [7:0] idx, input [7:0] e);
      begin
         host.io(1'b1, 1'b0, pb, idx);
         host.io(1'b0, 1'b0, pb + 16'h1, 8'h00);
         `CHK(O_IO_DONE, 1'b1)
         `CHK(O_IO_RDATA, e)
      end
   endtask
   initial begin
      rst(3'h0);
      `CHK(O_PORTAL_BASE, 16'h008C)
      host.io(1'b1, 1'b1, 16'h008C, 8'h55);
      `CHK(O_IO_FWD, 1'b1)
      wr_reg(8'h07, 8'h01);
      repeat (3) @(negedge I_CLOCK);
      host.io(1'b0, 1'b0, 16'h008D, 8'h00);
      `CHK(O_IO_RDATA, 8'hFF)
      host.io(1'b1, 1'b0, pb, 8'h55);
      rd_reg(8'h07, 8'h00);
      `CHK(O_PORTAL_OPEN, 1'b1)
      for (i = 0; i < 3; i = i + 1) begin
         wr_reg(8'h07, i[7:0]);
         wr_reg(8'h40, 8'h5A ^ i[7:0]);
      end
      for (i = 0; i < 3; i = i + 1) begin
         wr_reg(8'h07, i[7:0]);
         rd_reg(8'h40, i == 2 ? 8'h00 : 8'h5A ^ i[7:0]);
      end
      rd_reg(8'h07, 8'h02);
      `CHK(O_BANK_SEL, 8'h02)
      wr_reg(8'h20, 8'hFF);
      rd_reg(8'h20, 8'h00);
      wr_reg(8'h36, 8'h21);
      pb = 16'h0020;
      wr_reg(8'h37, 8'h03);
      pb = 16'h0320;
      @(negedge I_CLOCK);
      `CHK(O_PORTAL_BASE, pb)
      host.io(1'b0, 1'b0, 16'h008C, 8'h00);
      `CHK(O_IO_FWD, 1'b1)
      host.io(1'b1, 1'b0, pb, 8'hAA);
      repeat (3) @(negedge I_CLOCK);
      host.io(1'b0, 1'b0, pb + 16'h1, 8'h00);
      `CHK(O_IO_RDATA, 8'hFF)
      `CHK(O_IO_FWD, 1'b0)
      host.io(1'b1, 1'b0, pb, 8'h55);
      host.cfg(1'b1, 8'h10, 32'hFFFFFFFF);
      host.cfg(1'b0, 8'h10, 32'h0);
      `CHK(O_CFG_RDATA, 32'h00007717)
      host.cfg(1'b1, 8'h20, 32'hFFFFFFFF);
      host.cfg(1'b0, 8'h20, 32'h0);
      `CHK(O_CFG_RDATA, 32'h003F3F03)
      rst(3'h6);
      `CHK(O_PORTAL_OPEN, 1'b0)
      host.cfg(1'b0, 8'h10, 32'h0);
      `CHK(O_CFG_RDATA, 32'h00001113)
      host.cfg(1'b0, 8'h20, 32'h0);
      `CHK(O_CFG_RDATA, 32'h003F3F03)
      rst(3'h5);
      host.cfg(1'b0, 8'h20, 32'h0);
      `CHK(O_CFG_RDATA, 32'h00003F00)
      end_of_test;
   end
endmodule // ecrb_top_tb
